// [vcr_dev.sv]
// Configuration and status register group of a VMEbus interface.
// Assumes the local port and the VME port are synchronous to clk.
// How it works
// R1 - Comm write sets its status bit
// R2 - Software sets sysfail mask after reset
// R3 - Status bit 5 read-only, bit 6 halt/reset
// R4 - Enabled request write asserts interrupt level
// R5 - Disabled request write clears addressed bits
// R6 - Acknowledge returns that level's vector
// R7 - Timeout bit 0 includes bus acquisition
// R8 - System controller flags arbitration timeout
// R9 - Software programs local timeout 011
// R10 - Software programs VME timeout 100
// R11 - Local timeout expires first or off
// R12 - Software leaves address strobe assertion zero
// R13 - Software sets strobe bit 4, 110
// R14 - Software sets dual path, clears turbo
// R15 - Bit 1 selects user address modifiers
// R16 - Software sets both 256-byte boundary bits
// R17 - Bits 4, 6 enable 64-bit master/slave
// R18 - Software aligns 2 KB, avoids 64 KB
// R19 - Control bit 0 shows controller pin
// R20 - Software clears turbo and deadlock bits
// R21 - Control bits 7-5 read-modify-write control
// R22 - Comm registers reachable from both ports
`timescale 1ns/1ps
module vcr_dev
  import vcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Local bus register port
  vcr_bus_if.dev bus,
  // VMEbus register port
  input wire logic [7:0] vme_addr,
  input wire logic [7:0] vme_wdata,
  input wire logic vme_wr,
  input wire logic vme_rd,
  output logic [7:0] vme_rdata,
  // Interrupter
  output logic [7:1] vme_irq,
  input wire logic iack,
  input wire logic [2:0] iack_level,
  output logic [7:0] iack_vector,
  output logic iack_valid,
  // Status inputs
  input wire logic sysctl_pin,
  input wire logic halt_status,
  input wire logic arb_timeout,
  // Configuration outputs
  output logic sysfail_assert,
  output logic halt_reset_ctl,
  output logic include_acq_time,
  output logic [2:0] local_timeout_code,
  output logic [2:0] vme_timeout_code,
  output logic [7:0] strobe_timing,
  output logic [7:0] block_def,
  output logic [7:0] block_am_code,
  output logic [2:0] rmw_control,
  output logic [4:0] if_control_misc
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0][7:0] comm;
    logic [7:0] comm_status;
    logic irq_en;
    logic [7:1] irq_req;
    logic [7:1][7:0] vec;
    logic [7:0] tmo;
    logic [7:0] lbt;
    logic [7:0] btd;
    logic [7:0] ifc;
    logic [7:0] ams;
    logic [7:0] lrdata;
    logic [7:0] vrdata;
    logic [7:1] irq_out;
    logic [7:0] vec_out;
    logic vec_valid;
    logic sysfail;
    logic [7:0] am_out;
  } vcr_dev_state_type;

  vcr_dev_state_type s_q;
  vcr_dev_state_type s_d;

  // ----------------------------------------------------------------
  // Access helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(vcr_dev_state_type s, logic [7:0] a, logic pin, logic halt);
    logic [7:0] r;
    r = 8'h00;
    if (a <= OFS_COMM4) begin
      r = s.comm[a[2:0]]; // R22
    end else if (a == OFS_COMM_STATUS) begin
      r = s.comm_status;
      r[ST_RO_BIT] = halt; // R3
    end else if (a == OFS_IRQ_REQ) begin
      r = {s.irq_req, s.irq_en};
    end else if (a >= OFS_VEC1 && a <= OFS_VEC7) begin
      r = s.vec[3'(a - OFS_VEC1 + 8'h01)];
    end else if (a == OFS_TIMEOUT) begin
      r = s.tmo;
    end else if (a == OFS_STROBE_TIMING) begin
      r = s.lbt;
    end else if (a == OFS_BLOCK_DEF) begin
      r = s.btd;
    end else if (a == OFS_IF_CONTROL) begin
      r = s.ifc;
      r[CTL_SYSCTL_BIT] = pin; // R19
    end else if (a == OFS_AM_SOURCE) begin
      r = s.ams;
    end
    return r;
  endfunction : read_reg

  function automatic vcr_dev_state_type write_reg(vcr_dev_state_type s, logic [7:0] a, logic [7:0] d);
    vcr_dev_state_type n;
    n = s;
    if (a <= OFS_COMM4) begin
      n.comm[a[2:0]] = d; // R22
    end else if (a == OFS_COMM_STATUS) begin
      n.comm_status = d;
      n.comm_status[ST_RO_BIT] = 1'b0; // R3
    end else if (a == OFS_IRQ_REQ) begin
      n.irq_en = d[IRQ_EN_BIT];
      if (d[IRQ_EN_BIT]) begin
        n.irq_req = s.irq_req | d[7:1]; // R4
      end else begin
        n.irq_req = s.irq_req & ~d[7:1]; // R5
      end
    end else if (a >= OFS_VEC1 && a <= OFS_VEC7) begin
      n.vec[3'(a - OFS_VEC1 + 8'h01)] = d; // R6
    end else if (a == OFS_TIMEOUT) begin
      n.tmo = d;
    end else if (a == OFS_STROBE_TIMING) begin
      n.lbt = d;
    end else if (a == OFS_BLOCK_DEF) begin
      n.btd = d;
    end else if (a == OFS_IF_CONTROL) begin
      n.ifc = d;
      n.ifc[CTL_SYSCTL_BIT] = 1'b0; // R19
    end else if (a == OFS_AM_SOURCE) begin
      n.ams = d;
    end
    return n;
  endfunction : write_reg

  function automatic logic [4:0] comm_hit(logic w, logic [7:0] a);
    logic [4:0] m;
    m = 5'h00;
    if (w && a <= OFS_COMM4) begin
      m[a[2:0]] = 1'b1;
    end
    return m;
  endfunction : comm_hit

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.vec_valid = 1'b0;
    // Acknowledge clears its request before new writes land
    if (iack && iack_level != 3'h0) begin
      s_d.vec_out = s_q.vec[iack_level]; // R6
      s_d.vec_valid = 1'b1;
      s_d.irq_req[iack_level] = 1'b0;
    end
    if (vme_wr) begin
      s_d = write_reg(s_d, vme_addr, vme_wdata);
    end
    if (bus.wr) begin
      s_d = write_reg(s_d, bus.addr, bus.wdata);
    end
    // Hardware sets win over software clears
    s_d.comm_status[4:0] = s_d.comm_status[4:0] | comm_hit(vme_wr, vme_addr)
      | comm_hit(bus.wr, bus.addr); // R1
    if (arb_timeout && sysctl_pin) begin
      s_d.tmo[TMO_ARB_BIT] = 1'b1; // R8
    end
    s_d.lrdata = bus.rd ? read_reg(s_q, bus.addr, sysctl_pin, halt_status) : 8'h00;
    s_d.vrdata = vme_rd ? read_reg(s_q, vme_addr, sysctl_pin, halt_status) : 8'h00;
    s_d.irq_out = s_d.irq_req; // R4
    s_d.sysfail = ~s_d.comm_status[ST_SYSFAIL_MASK_BIT];
    s_d.am_out = s_d.btd[BTD_AM_USER_BIT] ? s_d.ams : 8'h00; // R15
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.rdata = s_q.lrdata;
  assign vme_rdata = s_q.vrdata;
  assign vme_irq = s_q.irq_out;
  assign iack_vector = s_q.vec_out;
  assign iack_valid = s_q.vec_valid;
  assign sysfail_assert = s_q.sysfail;
  assign halt_reset_ctl = s_q.comm_status[ST_HALT_BIT]; // R3
  assign include_acq_time = s_q.tmo[TMO_ACQ_BIT]; // R7
  assign local_timeout_code = s_q.tmo[4:2];
  assign vme_timeout_code = s_q.tmo[7:5];
  assign strobe_timing = s_q.lbt;
  assign block_def = s_q.btd; // R17
  assign block_am_code = s_q.am_out;
  assign rmw_control = s_q.ifc[7:5]; // R21
  assign if_control_misc = s_q.ifc[4:0];
endmodule : vcr_dev

// [vcr_pkg.sv]
// Constants and types shared by both ends of the VME configuration register group.
// Assumes one 250 MHz clock and an asynchronous active-low reset at each end.
package vcr_pkg;
  // ----------------------------------------------------------------
  // Register offsets on the register access port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COMM0 = 8'h00;
  localparam logic [7:0] OFS_COMM4 = 8'h04;
  localparam logic [7:0] OFS_COMM_STATUS = 8'h07;
  localparam logic [7:0] OFS_IRQ_REQ = 8'h08;
  localparam logic [7:0] OFS_VEC1 = 8'h09;
  localparam logic [7:0] OFS_VEC7 = 8'h0f;
  localparam logic [7:0] OFS_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_STROBE_TIMING = 8'h11;
  localparam logic [7:0] OFS_BLOCK_DEF = 8'h12;
  localparam logic [7:0] OFS_IF_CONTROL = 8'h13;
  localparam logic [7:0] OFS_AM_SOURCE = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_RO_BIT = 5;
  localparam int ST_HALT_BIT = 6;
  localparam int ST_SYSFAIL_MASK_BIT = 7;
  localparam int IRQ_EN_BIT = 0;
  localparam int TMO_ACQ_BIT = 0;
  localparam int TMO_ARB_BIT = 1;
  localparam int BTD_AM_USER_BIT = 1;
  localparam int BTD_D64_MASTER_BIT = 4;
  localparam int BTD_D64_SLAVE_BIT = 6;
  localparam int CTL_SYSCTL_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values and values the controller programs after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] INIT_COMM_STATUS = 8'h80;
  localparam logic [7:0] INIT_TIMEOUT = 8'h8c;
  localparam logic [7:0] INIT_STROBE_TIMING = 8'hd0;
  localparam logic [7:0] INIT_BLOCK_DEF = 8'h4d;
  localparam logic [7:0] INIT_IF_CONTROL = 8'h00;
  localparam logic [2:0] INIT_STEPS = 3'h5;
  // ----------------------------------------------------------------
  // Controller software port
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_HOST_ADDR = 4'h0;
  localparam logic [3:0] OFS_HOST_DATA = 4'h4;
  localparam logic [3:0] OFS_HOST_CMD = 4'h8;
  localparam logic [3:0] OFS_HOST_STATUS = 4'hc;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  typedef enum logic [1:0] {
    HS_INIT = 2'b00,
    HS_IDLE = 2'b01,
    HS_RWAIT = 2'b10
  } vcr_host_state_type;
endpackage : vcr_pkg

// [vcr_bus_if.sv]
// Register access link between the controller end and the register group.
// Assumes both ends share clk and reset_n.
`timescale 1ns/1ps
interface vcr_bus_if (
  input wire logic clk,
  input wire logic reset_n
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : vcr_bus_if

// [vcr_host.sv]
// Controller end: programs the register group after reset, then runs
// single reads and writes ordered by software through its own registers.
// Assumes a register group answering reads one cycle after the strobe.
`timescale 1ns/1ps
module vcr_host
  import vcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Register group link
  vcr_bus_if.host bus
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    vcr_host_state_type st;
    logic [2:0] step;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [7:0] rdat;
    logic [31:0] sw_rdata;
  } vcr_host_state_type_s_type;

  vcr_host_state_type_s_type s_q;
  vcr_host_state_type_s_type s_d;

  // Post-reset programming sequence
  function automatic logic [15:0] init_entry(logic [2:0] i);
    case (i)
      3'h0: init_entry = {OFS_COMM_STATUS, INIT_COMM_STATUS}; // R2
      3'h1: init_entry = {OFS_TIMEOUT, INIT_TIMEOUT}; // R9 R10 R11
      3'h2: init_entry = {OFS_STROBE_TIMING, INIT_STROBE_TIMING}; // R12 R13
      3'h3: init_entry = {OFS_BLOCK_DEF, INIT_BLOCK_DEF}; // R14 R16 R18
      default: init_entry = {OFS_IF_CONTROL, INIT_IF_CONTROL}; // R20
    endcase
  endfunction : init_entry

  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.sw_rdata = 32'h0000_0000;
    if (sw_wr && sw_addr == OFS_HOST_ADDR) begin
      s_d.cmd_addr = sw_wdata[7:0];
    end
    if (sw_wr && sw_addr == OFS_HOST_DATA) begin
      s_d.cmd_data = sw_wdata[7:0];
    end
    if (sw_rd) begin
      case (sw_addr)
        OFS_HOST_ADDR: s_d.sw_rdata = {24'h00_0000, s_q.cmd_addr};
        OFS_HOST_DATA: s_d.sw_rdata = {24'h00_0000, s_q.cmd_data};
        OFS_HOST_STATUS: s_d.sw_rdata = {16'h0000, s_q.rdat, 7'h00, s_q.st != HS_IDLE};
        default: s_d.sw_rdata = 32'h0000_0000;
      endcase
    end
    case (s_q.st)
      HS_INIT: begin
        {s_d.addr, s_d.wdata} = init_entry(s_q.step);
        s_d.wr = 1'b1;
        s_d.step = s_q.step + 3'h1;
        if (s_q.step == INIT_STEPS - 3'h1) begin
          s_d.st = HS_IDLE;
        end
      end
      HS_IDLE: begin
        if (sw_wr && sw_addr == OFS_HOST_CMD) begin
          s_d.addr = s_q.cmd_addr;
          s_d.wdata = s_q.cmd_data;
          if (sw_wdata[CMD_WRITE_BIT]) begin
            s_d.wr = 1'b1;
          end else if (sw_wdata[CMD_READ_BIT]) begin
            s_d.rd = 1'b1;
            s_d.st = HS_RWAIT;
          end
        end
      end
      HS_RWAIT: begin
        if (!s_q.rd) begin
          s_d.rdat = bus.rdata;
          s_d.st = HS_IDLE;
        end
      end
      default: s_d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;
  assign bus.wr = s_q.wr;
  assign bus.rd = s_q.rd;
  assign sw_rdata = s_q.sw_rdata;
endmodule : vcr_host

// [vcr_chk.sv]
// Checker for the register link between controller end and register group.
// Assumes it watches the link signals of the one interface in tb_top.
`timescale 1ns/1ps
module vcr_chk
  import vcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  // ----------------------------------------------------------------
  // Shadow of plain read/write registers written over the link
  // ----------------------------------------------------------------
  function automatic logic plain(input logic [7:0] a);
    return a <= OFS_COMM4 || (a >= OFS_VEC1 && a <= OFS_VEC7) || a == OFS_STROBE_TIMING
      || a == OFS_BLOCK_DEF || a == OFS_AM_SOURCE;
  endfunction : plain
  logic [7:0] sh_q [0:31];
  logic [31:0] ok_q;
  logic [4:0] seen_q;
  always_ff @(posedge clk) begin
    if (wr && plain(addr)) begin
      sh_q[addr[4:0]] <= wdata;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ok_q <= '0;
      seen_q <= '0;
    end else if (wr) begin
      if (plain(addr)) begin
        ok_q[addr[4:0]] <= 1'b1;
      end
      if (addr == OFS_COMM_STATUS) begin
        seen_q <= wdata[4:0];
      end else if (addr <= OFS_COMM4) begin
        seen_q[addr[2:0]] <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_shadow;
    rd && plain(addr) && ok_q[addr[4:0]] |=> rdata == $past(sh_q[addr[4:0]]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("read data differs from value written");
  property p_flags;
    rd && addr == OFS_COMM_STATUS |=> (rdata[4:0] & $past(seen_q)) == $past(seen_q);
  endproperty
  a_flags: assert property (p_flags) else $error("comm write flag missing in status");
  property p_unmapped;
    rd && ((addr > OFS_COMM4 && addr < OFS_COMM_STATUS) || addr > OFS_AM_SOURCE) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");
  property p_one_strobe;
    !(wr && rd);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobes together");
  property p_init_status;
    $rose(reset_n) |=> wr && addr == OFS_COMM_STATUS && wdata == INIT_COMM_STATUS;
  endproperty
  a_init_status: assert property (p_init_status) else $error("status mask not set after reset");
  property p_init_timeout;
    $rose(reset_n) |=> ##1 wr && addr == OFS_TIMEOUT && wdata == INIT_TIMEOUT;
  endproperty
  a_init_timeout: assert property (p_init_timeout) else $error("timeout setup wrong");
  property p_init_strobe;
    $rose(reset_n) |=> ##2 wr && addr == OFS_STROBE_TIMING && wdata == INIT_STROBE_TIMING;
  endproperty
  a_init_strobe: assert property (p_init_strobe) else $error("strobe timing setup wrong");
  property p_init_block;
    $rose(reset_n) |=> ##3 wr && addr == OFS_BLOCK_DEF && wdata == INIT_BLOCK_DEF;
  endproperty
  a_init_block: assert property (p_init_block) else $error("block setup wrong");
  property p_init_ctl;
    $rose(reset_n) |=> ##4 wr && addr == OFS_IF_CONTROL && wdata == INIT_IF_CONTROL;
  endproperty
  a_init_ctl: assert property (p_init_ctl) else $error("control setup wrong");
endmodule : vcr_chk

// [tb_top.sv]
// Testbench joining controller end and register group over the link.
// Assumes the software port and the VME port answer one cycle after a strobe.
`timescale 1ns/1ps
module tb_top;
  import vcr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0, sw_rd = 1'b0, vme_wr = 1'b0, vme_rd = 1'b0, iack = 1'b0;
  logic sysctl_pin = 1'b0, halt_status = 1'b0, arb_timeout = 1'b0;
  logic [7:0] vme_addr = 8'h00, vme_wdata = 8'h00, r;
  logic [2:0] iack_level = 3'h0, local_timeout_code, vme_timeout_code, rmw_control;
  logic [31:0] sw_rdata;
  logic [7:0] vme_rdata, iack_vector, strobe_timing, block_def, block_am_code;
  logic [7:1] vme_irq;
  logic iack_valid, sysfail_assert, halt_reset_ctl, include_acq_time;
  logic [4:0] if_control_misc;
  logic [15:0] t16;
  int err_count = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  vcr_bus_if vcr_bus_if_inst (.clk(clk), .reset_n(reset_n));
  vcr_host vcr_host_inst (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(vcr_bus_if_inst));
  vcr_dev vcr_dev_inst (.clk(clk), .reset_n(reset_n), .bus(vcr_bus_if_inst), .vme_addr(vme_addr),
    .vme_wdata(vme_wdata), .vme_wr(vme_wr), .vme_rd(vme_rd), .vme_rdata(vme_rdata), .vme_irq(vme_irq),
    .iack(iack), .iack_level(iack_level), .iack_vector(iack_vector), .iack_valid(iack_valid),
    .sysctl_pin(sysctl_pin), .halt_status(halt_status), .arb_timeout(arb_timeout),
    .sysfail_assert(sysfail_assert), .halt_reset_ctl(halt_reset_ctl), .include_acq_time(include_acq_time),
    .local_timeout_code(local_timeout_code), .vme_timeout_code(vme_timeout_code), .strobe_timing(strobe_timing),
    .block_def(block_def), .block_am_code(block_am_code), .rmw_control(rmw_control),
    .if_control_misc(if_control_misc));
  vcr_chk vcr_chk_inst (.clk(clk), .reset_n(reset_n), .addr(vcr_bus_if_inst.addr),
    .wdata(vcr_bus_if_inst.wdata), .wr(vcr_bus_if_inst.wr), .rd(vcr_bus_if_inst.rd),
    .rdata(vcr_bus_if_inst.rdata));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sw_op(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [15:0] q);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= {24'h0, d};
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 q = sw_rdata[15:0];
  endtask : sw_op
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] t;
    sw_op(1'b1, OFS_HOST_ADDR, a, t);
    sw_op(1'b1, OFS_HOST_DATA, d, t);
    sw_op(1'b1, OFS_HOST_CMD, {6'h0, !w, w}, t);
    repeat (4) @(posedge clk);
    sw_op(1'b0, OFS_HOST_STATUS, 8'h00, t);
    q = t[15:8];
  endtask : dev
  task automatic vme(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    vme_addr <= a;
    vme_wdata <= d;
    vme_wr <= w;
    vme_rd <= !w;
    @(posedge clk);
    vme_wr <= 1'b0;
    vme_rd <= 1'b0;
    #1 q = vme_rdata;
    repeat (2) @(posedge clk);
    #1;
  endtask : vme
  task automatic pulse(input logic a, input logic [2:0] l);
    @(posedge clk);
    iack <= a;
    arb_timeout <= !a;
    iack_level <= l;
    @(posedge clk);
    iack <= 1'b0;
    arb_timeout <= 1'b0;
    #1;
  endtask : pulse
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #40000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    dev(1'b0, OFS_COMM_STATUS, 8'h00, r); chk(r, 8'h80);
    chk({7'h0, sysfail_assert}, 8'h00);
    chk({5'h0, local_timeout_code}, 8'h03);
    chk({5'h0, vme_timeout_code}, 8'h04);
    chk(strobe_timing, 8'hd0);
    chk(block_def, 8'h4d);
    chk({3'h0, if_control_misc}, 8'h00);
    $display("test init done");
    vme(1'b1, 8'h02, 8'ha5, r);
    dev(1'b0, 8'h02, 8'h00, r); chk(r, 8'ha5);
    dev(1'b1, OFS_COMM4, 8'h3c, r);
    vme(1'b0, OFS_COMM4, 8'h00, r); chk(r, 8'h3c);
    vme(1'b0, OFS_COMM_STATUS, 8'h00, r); chk(r, 8'h94);
    $display("test comm done");
    @(posedge clk) halt_status <= 1'b1;
    vme(1'b0, OFS_COMM_STATUS, 8'h00, r); chk(r, 8'hb4);
    @(posedge clk) halt_status <= 1'b0;
    vme(1'b1, OFS_COMM_STATUS, 8'h74, r);
    chk({6'h0, halt_reset_ctl, sysfail_assert}, 8'h03);
    vme(1'b0, OFS_COMM_STATUS, 8'h00, r); chk(r, 8'h54);
    vme(1'b1, OFS_COMM_STATUS, 8'h94, r);
    $display("test status done");
    vme(1'b1, OFS_IRQ_REQ, 8'h0b, r); chk({1'b0, vme_irq}, 8'h05);
    vme(1'b1, OFS_IRQ_REQ, 8'h02, r); chk({1'b0, vme_irq}, 8'h04);
    vme(1'b1, OFS_IRQ_REQ, 8'h81, r); chk({1'b0, vme_irq}, 8'h44);
    dev(1'b0, OFS_IRQ_REQ, 8'h00, r); chk(r, 8'h89);
    for (int l = 1; l <= 7; l++) begin
      dev(1'b1, OFS_IRQ_REQ + 8'(l), 8'h50 + 8'(l), r);
    end
    for (int l = 1; l <= 7; l++) begin
      pulse(1'b1, 3'(l));
      chk({7'h0, iack_valid}, 8'h01);
      chk(iack_vector, 8'h50 + 8'(l));
    end
    dev(1'b0, OFS_VEC7, 8'h00, r); chk(r, 8'h57);
    chk({1'b0, vme_irq}, 8'h00);
    $display("test interrupter done");
    dev(1'b1, OFS_TIMEOUT, 8'h8d, r); chk({7'h0, include_acq_time}, 8'h01);
    pulse(1'b0, 3'h0);
    dev(1'b0, OFS_TIMEOUT, 8'h00, r); chk(r, 8'h8d);
    @(posedge clk) sysctl_pin <= 1'b1;
    pulse(1'b0, 3'h0);
    dev(1'b0, OFS_TIMEOUT, 8'h00, r); chk(r, 8'h8f);
    dev(1'b0, OFS_IF_CONTROL, 8'h00, r); chk(r, 8'h01);
    @(posedge clk) sysctl_pin <= 1'b0;
    $display("test timeout done");
    dev(1'b1, OFS_AM_SOURCE, 8'h3a, r);
    dev(1'b1, OFS_BLOCK_DEF, 8'h5f, r); chk(block_am_code, 8'h3a);
    chk(block_def, 8'h5f);
    dev(1'b1, OFS_BLOCK_DEF, 8'h5d, r); chk(block_am_code, 8'h00);
    dev(1'b1, OFS_IF_CONTROL, 8'hff, r); chk({5'h0, rmw_control}, 8'h07);
    chk({3'h0, if_control_misc}, 8'h1e);
    sw_op(1'b0, OFS_HOST_ADDR, 8'h00, t16); chk(t16[7:0], OFS_IF_CONTROL);
    sw_op(1'b0, OFS_HOST_DATA, 8'h00, t16); chk(t16[7:0], 8'hff);
    dev(1'b0, OFS_IF_CONTROL, 8'h00, r); chk(r, 8'hfe);
    $display("test block and control done");
    dev(1'b1, 8'h05, 8'h77, r);
    dev(1'b0, 8'h05, 8'h00, r); chk(r, 8'h00);
    dev(1'b0, 8'h20, 8'h00, r); chk(r, 8'h00);
    vme(1'b0, 8'h06, 8'h00, r); chk(r, 8'h00);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : tb_top
